// >>> core/hub_bus_frame_control.sv
// Hub bus frame decoder, command path, protection and APB status slave.
`timescale 1ns/1ps
`include "hub_bus_frame_control_map.svh"
module hub_bus_frame_control #(
  parameter logic [31:0] PROG_CYCLES  = `PROG_TIME_NS / `CLK_PERIOD_NS,
  parameter logic [31:0] ERASE_CYCLES = `ERASE_TIME_NS / `CLK_PERIOD_NS
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        ce,
  input  wire logic [11:0] paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        init_n,
  input  wire logic        iface_select_strap,
  input  wire logic        frame_ctl_n,
  input  wire logic [3:0]  nibble_bus_in,
  output logic      [3:0]  nibble_bus_out,
  output logic             nibble_bus_oe,
  input  wire logic [3:0]  select_strap_pins,
  input  wire logic [4:0]  general_inputs,
  input  wire logic        top_boot_lock_n,
  input  wire logic        write_protect_n,
  output logic             ready_busy_out,
  output logic             ready_busy_oe,
  output logic             standby
);
  typedef hub_bus_frame_control_pkg::frame_st_t frame_st_t;
  localparam frame_st_t FR_IDLE    = hub_bus_frame_control_pkg::FR_IDLE;
  localparam frame_st_t FR_IDSEL   = hub_bus_frame_control_pkg::FR_IDSEL;
  localparam frame_st_t FR_ADDR    = hub_bus_frame_control_pkg::FR_ADDR;
  localparam frame_st_t FR_MSIZE   = hub_bus_frame_control_pkg::FR_MSIZE;
  localparam frame_st_t FR_WDATA   = hub_bus_frame_control_pkg::FR_WDATA;
  localparam frame_st_t FR_TAR_IN  = hub_bus_frame_control_pkg::FR_TAR_IN;
  localparam frame_st_t FR_SYNC    = hub_bus_frame_control_pkg::FR_SYNC;
  localparam frame_st_t FR_RDATA   = hub_bus_frame_control_pkg::FR_RDATA;
  localparam frame_st_t FR_TAR_OUT = hub_bus_frame_control_pkg::FR_TAR_OUT;
  localparam frame_st_t FR_ABORT   = hub_bus_frame_control_pkg::FR_ABORT;
  localparam frame_st_t FR_SKIP    = hub_bus_frame_control_pkg::FR_SKIP;

  frame_st_t state_q, state_d;
  hub_bus_frame_control_pkg::mode_t mode_q, mode_d;
  hub_bus_frame_control_pkg::pend_t pend_q, pend_d;
  hub_bus_frame_control_pkg::status_t st_q, st_d;
  logic [2:0]  cnt_q, cnt_d, low_q, low_d;
  logic [27:0] addr_q, addr_d;
  logic [7:0]  dat_q, dat_d;
  logic        rd_q, rd_d, hub_en_q, hub_en_d, strap_ok_q, strap_ok_d;
  logic        aa_mode_q, aa_mode_d;
  logic [3:0]  id_q, id_d, nib_q, nib_d;
  logic        nib_oe_q, nib_oe_d, rb_oe_q, rb_oe_d, stby_q, stby_d;
  logic [31:0] busy_q, busy_d, prdata_q, prdata_d;
  logic        pready_q, pready_d, pslverr_q, pslverr_d;
  logic        apb_take, apb_done, clr_err, apb_stat_rd, busy, abort_hit;

  // Decodes a start nibble; 1 when it opens a read or write cycle.
  function automatic logic start_ok(input logic [3:0] n);
    start_ok = (n == `START_READ) || (n == `START_WRITE);
  endfunction

  // A target is protected when its lock input is low.
  function automatic logic locked(input logic [27:0] a);
    if (a[19:16] == `BOOT_BLOCK)
      locked = !top_boot_lock_n;
    else
      locked = !write_protect_n;
  endfunction

  assign busy      = (busy_q != 32'h0000_0000);
  assign apb_take  = psel && penable && !pready_q;
  assign apb_done  = psel && penable && pready_q;
  assign clr_err   = apb_done && pwrite && (paddr == `CTRL_OFF) &&
                     pwdata[`CTRL_CLR_ERR];
  assign apb_stat_rd = apb_done && !pwrite && (paddr == `STAT_OFF);

  // APB slave: one wait state, answer held until the master's sampling edge.
  always_comb begin
    pready_d  = apb_take;
    prdata_d  = prdata_q;
    pslverr_d = 1'b0;
    hub_en_d  = hub_en_q;
    if (apb_take) begin
      prdata_d = 32'h0000_0000;
      unique case (paddr)
        `CTRL_OFF:  prdata_d = {31'h0, hub_en_q};
        `STAT_OFF:  prdata_d = {21'h0, state_q == FR_ABORT, aa_mode_q,
                                stby_q, st_q};
        `GPI_OFF:   prdata_d = {27'h0, general_inputs};
        `STRAP_OFF: prdata_d = {28'h0, id_q};
        default:    pslverr_d = 1'b1;
      endcase
    end
    if (apb_done && pwrite && (paddr == `CTRL_OFF))
      hub_en_d = pwdata[`CTRL_HUB_EN];
    if (!init_n)
      hub_en_d = `CTRL_RST;
  end

  always_comb begin
    state_d   = state_q;
    cnt_d     = cnt_q;
    addr_d    = addr_q;
    dat_d     = dat_q;
    rd_d      = rd_q;
    mode_d    = mode_q;
    pend_d    = pend_q;
    st_d      = st_q;
    id_d      = id_q;
    aa_mode_d = aa_mode_q;
    strap_ok_d = 1'b1;
    busy_d    = busy ? busy_q - 32'h0000_0001 : busy_q;
    low_d     = frame_ctl_n ? 3'h0 :
                (low_q == `ABORT_LOW_CLKS) ? low_q : low_q + 3'h1;
    abort_hit = !frame_ctl_n && (low_q >= `ABORT_LOW_CLKS - 3'h1) &&
                (state_q != FR_IDLE) && (state_q != FR_SKIP) &&
                (state_q != FR_ABORT);
    if (!strap_ok_q) begin
      aa_mode_d = iface_select_strap;
      id_d      = select_strap_pins;
    end
    if (clr_err)
      st_d.err = 6'h00;
    if (apb_stat_rd && busy)
      st_d.toggle = !st_q.toggle;
    unique case (state_q)
      FR_IDLE, FR_SKIP, FR_IDSEL: begin
        if (!frame_ctl_n) begin
          // Frame low is a start slot; anything unknown is ignored.
          if (start_ok(nibble_bus_in) && hub_en_q && !aa_mode_q) begin
            state_d = FR_IDSEL;
            rd_d    = (nibble_bus_in == `START_READ);
          end else begin
            state_d = FR_IDLE;
          end
        end else if (state_q == FR_IDSEL) begin
          cnt_d   = 3'h0;
          state_d = (nibble_bus_in == id_q) ? FR_ADDR : FR_SKIP;
        end
      end
      FR_ADDR: begin
        addr_d = {addr_q[23:0], nibble_bus_in};
        cnt_d  = cnt_q + 3'h1;
        if (cnt_q == `ADDR_NIBS - 3'h1) begin
          state_d = FR_MSIZE;
          cnt_d   = 3'h0;
        end
      end
      FR_MSIZE: state_d = rd_q ? FR_TAR_IN : FR_WDATA;
      FR_WDATA: begin
        cnt_d = cnt_q + 3'h1;
        if (cnt_q == 3'h0) begin
          dat_d[3:0] = nibble_bus_in;
        end else begin
          dat_d[7:4] = nibble_bus_in;
          state_d    = FR_TAR_IN;
          cnt_d      = 3'h0;
        end
      end
      FR_TAR_IN: begin
        cnt_d = cnt_q + 3'h1;
        if (cnt_q == 3'h1) begin
          state_d = FR_SYNC;
          cnt_d   = 3'h0;
        end
      end
      FR_SYNC: state_d = rd_q ? FR_RDATA : FR_TAR_OUT;
      FR_RDATA, FR_TAR_OUT: begin
        cnt_d = cnt_q + 3'h1;
        if (cnt_q == 3'h1) begin
          state_d = (state_q == FR_RDATA) ? FR_TAR_OUT : FR_IDLE;
          cnt_d   = 3'h0;
        end
      end
      FR_ABORT: begin
        // The bus is back with the host; leave when the frame line rises.
        if (frame_ctl_n)
          state_d = FR_IDLE;
      end
      default: state_d = FR_IDLE;
    endcase
    // Byte transfer at the end of the input turn-around.
    if (state_q == FR_TAR_IN && cnt_q == 3'h1 && !abort_hit) begin
      if (rd_q) begin
        if (addr_q[22:0] == `GPI_ADDR)
          dat_d = {3'h0, general_inputs};
        else if (mode_q == hub_bus_frame_control_pkg::MODE_STATUS || busy)
        begin
          dat_d = st_q;
          if (busy)
            st_d.toggle = !st_q.toggle;
        end else
          dat_d = `ARRAY_FILL;
      end else if (!busy) begin
        // Commands ride on plain memory writes; ignored while busy.
        mode_d = hub_bus_frame_control_pkg::MODE_STATUS;
        pend_d = hub_bus_frame_control_pkg::PEND_NONE;
        unique case (pend_q)
          hub_bus_frame_control_pkg::PEND_PROG: begin
            if (locked(addr_q))
              st_d.err = st_d.err | 6'h12;
            else
              busy_d = PROG_CYCLES;
          end
          hub_bus_frame_control_pkg::PEND_ERASE: begin
            if (dat_q != `CMD_ERASE_CONFIRM) begin
              st_d.err[`ERR_ERASE] = 1'b1;
              st_d.err[`ERR_PROG]  = 1'b1;
            end else if (locked(addr_q)) begin
              st_d.err[`ERR_PROT]  = 1'b1;
              st_d.err[`ERR_ERASE] = 1'b1;
            end else
              busy_d = ERASE_CYCLES;
          end
          default: begin
            unique case (dat_q)
              `CMD_READ_ARRAY:
                mode_d = hub_bus_frame_control_pkg::MODE_ARRAY;
              `CMD_READ_STATUS: ;
              `CMD_CLEAR_STATUS: st_d.err = 6'h00;
              `CMD_ERASE_SETUP:
                pend_d = hub_bus_frame_control_pkg::PEND_ERASE;
              `CMD_PROG_SETUP, `CMD_PROG_ALT:
                pend_d = hub_bus_frame_control_pkg::PEND_PROG;
              default: mode_d = hub_bus_frame_control_pkg::MODE_ARRAY;
            endcase
          end
        endcase
      end
    end
    if (abort_hit)
      state_d = FR_ABORT;
    st_d.done = (busy_d == 32'h0000_0000);
    nib_d    = `TAR_DRIVE;
    nib_oe_d = 1'b0;
    unique case (state_d)
      FR_SYNC: begin
        nib_d    = `SYNC_READY;
        nib_oe_d = 1'b1;
      end
      FR_RDATA: begin
        nib_d    = (cnt_d == 3'h0) ? dat_d[3:0] : dat_d[7:4];
        nib_oe_d = 1'b1;
      end
      FR_TAR_OUT: nib_oe_d = (cnt_d == 3'h0);
      default: ;
    endcase
    rb_oe_d = !st_d.done;
    stby_d  = frame_ctl_n && !rb_oe_d && (state_d == FR_IDLE);
    if (!init_n) begin
      // Second reset returns the frame, command and status logic and hub enable to hard-reset values; address, data and other APB registers keep theirs.
      state_d    = FR_IDLE;
      mode_d     = hub_bus_frame_control_pkg::MODE_ARRAY;
      pend_d     = hub_bus_frame_control_pkg::PEND_NONE;
      busy_d     = 32'h0000_0000;
      st_d       = 8'h80;
      cnt_d      = 3'h0;
      low_d      = 3'h0;
      strap_ok_d = 1'b0;
      nib_oe_d   = 1'b0;
      rb_oe_d    = 1'b0;
      stby_d     = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q    <= FR_IDLE;
      mode_q     <= hub_bus_frame_control_pkg::MODE_ARRAY;
      pend_q     <= hub_bus_frame_control_pkg::PEND_NONE;
      st_q       <= 8'h80;
      cnt_q      <= 3'h0;
      low_q      <= 3'h0;
      addr_q     <= 28'h0000000;
      dat_q      <= 8'h00;
      rd_q       <= 1'b0;
      hub_en_q   <= `CTRL_RST;
      strap_ok_q <= 1'b0;
      aa_mode_q  <= 1'b0;
      id_q       <= 4'h0;
      nib_q      <= `TAR_DRIVE;
      nib_oe_q   <= 1'b0;
      rb_oe_q    <= 1'b0;
      stby_q     <= 1'b0;
      busy_q     <= 32'h0000_0000;
      prdata_q   <= 32'h0000_0000;
      pready_q   <= 1'b0;
      pslverr_q  <= 1'b0;
    end else if (ce) begin
      state_q    <= state_d;
      mode_q     <= mode_d;
      pend_q     <= pend_d;
      st_q       <= st_d;
      cnt_q      <= cnt_d;
      low_q      <= low_d;
      addr_q     <= addr_d;
      dat_q      <= dat_d;
      rd_q       <= rd_d;
      hub_en_q   <= hub_en_d;
      strap_ok_q <= strap_ok_d;
      aa_mode_q  <= aa_mode_d;
      id_q       <= id_d;
      nib_q      <= nib_d;
      nib_oe_q   <= nib_oe_d;
      rb_oe_q    <= rb_oe_d;
      stby_q     <= stby_d;
      busy_q     <= busy_d;
      prdata_q   <= prdata_d;
      pready_q   <= pready_d;
      pslverr_q  <= pslverr_d;
    end
  end

  assign prdata         = prdata_q;
  assign pready         = pready_q;
  assign pslverr        = pslverr_q;
  assign nibble_bus_out = nib_q;
  assign nibble_bus_oe  = nib_oe_q;
  assign ready_busy_out = 1'b0;
  assign ready_busy_oe  = rb_oe_q;
  assign standby        = stby_q;
endmodule

// >>> core/hub_bus_frame_control_map.svh
// Offsets, field positions, reset values and timing counts of the hub bus front end.
`ifndef HUB_BUS_FRAME_CONTROL_MAP_SVH
`define HUB_BUS_FRAME_CONTROL_MAP_SVH
`define CTRL_OFF          12'h000
`define STAT_OFF          12'h004
`define GPI_OFF           12'h008
`define STRAP_OFF         12'h00C
`define CTRL_HUB_EN       0
`define CTRL_CLR_ERR      1
`define CTRL_RST          1'h1
`define START_READ        4'hD
`define START_WRITE       4'hE
`define ABORT_CODE        4'hF
`define SYNC_READY        4'h0
`define TAR_DRIVE         4'hF
`define ABORT_LOW_CLKS    3'h4
`define ADDR_NIBS         3'h7
`define CMD_READ_ARRAY    8'hFF
`define CMD_READ_STATUS   8'h70
`define CMD_CLEAR_STATUS  8'h50
`define CMD_ERASE_SETUP   8'h20
`define CMD_ERASE_CONFIRM 8'hD0
`define CMD_PROG_SETUP    8'h40
`define CMD_PROG_ALT      8'h10
`define ERR_ERASE         5
`define ERR_PROG          4
`define ERR_PROT          1
`define GPI_ADDR          23'h3C0100
`define BOOT_BLOCK        4'hF
`define ARRAY_FILL        8'hFF
`define CLK_PERIOD_NS     5
`define PROG_TIME_NS      25000
`define ERASE_TIME_NS     600000000
`endif

// >>> core/hub_bus_frame_control_pkg.sv
// Types shared by the hub bus front end.
package hub_bus_frame_control_pkg;
  typedef enum logic [3:0] {
    FR_IDLE   = 4'h0,
    FR_IDSEL  = 4'h1,
    FR_ADDR   = 4'h2,
    FR_MSIZE  = 4'h3,
    FR_WDATA  = 4'h4,
    FR_TAR_IN = 4'h5,
    FR_SYNC   = 4'h6,
    FR_RDATA  = 4'h7,
    FR_TAR_OUT = 4'h8,
    FR_ABORT  = 4'h9,
    FR_SKIP   = 4'hA
  } frame_st_t;
  typedef enum logic {
    MODE_ARRAY  = 1'b0,
    MODE_STATUS = 1'b1
  } mode_t;
  typedef enum logic [1:0] {
    PEND_NONE  = 2'h0,
    PEND_ERASE = 2'h1,
    PEND_PROG  = 2'h2
  } pend_t;
  typedef struct packed {
    logic       done;
    logic       toggle;
    logic [5:0] err;
  } status_t;
endpackage

// >>> sim/hub_bus_frame_control_properties.sv
// Port checker of the hub bus front end.
`timescale 1ns/1ps
module hub_bus_frame_control_checker (
  input wire logic       pclk,
  input wire logic       presetn,
  input wire logic       ce,
  input wire logic       psel,
  input wire logic       penable,
  input wire logic       pready,
  input wire logic       init_n,
  input wire logic       frame_ctl_n,
  input wire logic [3:0] nibble_bus_out,
  input wire logic       nibble_bus_oe,
  input wire logic       ready_busy_oe,
  input wire logic       standby
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  property p_apb;
    psel && penable && !pready && ce |=> pready;
  endproperty
  a_apb: assert property (p_apb) else $error("late apb answer");
  property p_init;
    !init_n && ce |=> !ready_busy_oe && !nibble_bus_oe;
  endproperty
  a_init: assert property (p_init) else $error("bad init");
  property p_stby;
    (!frame_ctl_n && ce |=> !standby) and (standby |-> !ready_busy_oe);
  endproperty
  a_stby: assert property (p_stby) else $error("bad standby");
  property p_abort;
    (!frame_ctl_n && ce) [*4] |=> !nibble_bus_oe;
  endproperty
  a_abort: assert property (p_abort) else $error("no abort");
  property p_sync;
    $rose(nibble_bus_oe) |-> nibble_bus_out == 4'h0 && $past(frame_ctl_n);
  endproperty
  a_sync: assert property (p_sync) else $error("bad sync");
  property p_hold;
    $rose(nibble_bus_oe) |-> nibble_bus_oe [*2];
  endproperty
  a_hold: assert property (p_hold) else $error("short drive");
  property p_tar;
    $fell(nibble_bus_oe) && $past(init_n) |-> $past(nibble_bus_out) == 4'hF;
  endproperty
  a_tar: assert property (p_tar) else $error("bad turn");
  property p_busy;
    $rose(ready_busy_oe) |-> ready_busy_oe [*8];
  endproperty
  a_busy: assert property (p_busy) else $error("short busy");
  c_busy: cover property ($fell(ready_busy_oe));
  c_abort: cover property ((!frame_ctl_n) [*4]);
  c_read: cover property ($rose(nibble_bus_oe) ##1 nibble_bus_oe [*3]);
endmodule
bind hub_bus_frame_control hub_bus_frame_control_checker checker_i (
  .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
  .pready(pready), .init_n(init_n), .frame_ctl_n(frame_ctl_n),
  .nibble_bus_out(nibble_bus_out), .nibble_bus_oe(nibble_bus_oe),
  .ready_busy_oe(ready_busy_oe), .standby(standby));

// >>> sim/hub_host.sv
// Host model of the nibble bus: frames cycles and resolves the wire.
`timescale 1ns/1ps
module hub_host (
  input  wire logic       pclk,
  output logic            frame_ctl_n,
  output logic [3:0]      nibble_bus_in,
  input  wire logic [3:0] nibble_bus_out,
  input  wire logic       nibble_bus_oe
);
  logic [3:0] h_d = 4'h0;
  logic       h_oe = 1'h0;
  logic [3:0] last_q = 4'h0;
  initial frame_ctl_n = 1'h1;
  // A released wire shows the inverse of its last level, never a stale copy.
  always @(posedge pclk) last_q <= nibble_bus_in;
  assign nibble_bus_in = nibble_bus_oe ? nibble_bus_out :
                         h_oe ? h_d : ~last_q;
  task automatic nib(input logic f, input logic [3:0] v);
    frame_ctl_n <= f;
    h_d <= v;
    h_oe <= 1'h1;
    @(posedge pclk);
  endtask
  task automatic rel();
    h_oe <= 1'h0;
    frame_ctl_n <= 1'h1;
    @(posedge pclk);
  endtask
  task automatic cycle(input logic [3:0] s, input logic [3:0] id,
    input logic [27:0] a, input logic [7:0] d,
    output logic [7:0] q, output logic ok);
    int k;
    nib(1'h0, s);
    nib(1'h1, id);
    for (int i = 6; i >= 0; i--) nib(1'h1, a[i*4 +: 4]);
    nib(1'h1, 4'h0);
    if (s == 4'hE) begin
      nib(1'h1, d[3:0]);
      nib(1'h1, d[7:4]);
    end
    nib(1'h1, 4'hF);
    rel();
    k = 0;
    while (nibble_bus_oe !== 1'h1 && k < 3) begin
      @(posedge pclk);
      k++;
    end
    ok = nibble_bus_oe === 1'h1 && nibble_bus_in === 4'h0;
    q = 8'h00;
    if (ok && s == 4'hD) begin
      @(posedge pclk);
      q[3:0] = nibble_bus_in;
      @(posedge pclk);
      q[7:4] = nibble_bus_in;
    end
    if (ok) @(posedge pclk);
    @(posedge pclk);
  endtask
endmodule

// >>> sim/tb.sv
// Self-checking bench of the hub bus front end.
`timescale 1ns/1ps
module tb;
  localparam logic [3:0]  ID = 4'hA;
  localparam logic [27:0] A_GPI = 28'hFBC0100;
  localparam logic [27:0] A_MN = 28'hFF00010;
  localparam logic [27:0] A_BT = 28'hFFF0010;
  logic        pclk = 1'h0;
  logic        presetn = 1'h0;
  logic        init_n = 1'h1;
  logic        iface_select_strap = 1'h0;
  logic        top_boot_lock_n = 1'h1;
  logic        write_protect_n = 1'h1;
  logic        psel = 1'h0;
  logic        penable = 1'h0;
  logic        pwrite = 1'h0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        frame_ctl_n;
  logic [3:0]  nibble_bus_in;
  logic [3:0]  nibble_bus_out;
  logic        nibble_bus_oe;
  logic        ready_busy_oe;
  logic        ready_busy_out;
  logic [4:0]  gpi = 5'h15;
  logic        standby;
  logic [31:0] q;
  logic        e;
  logic [7:0]  b;
  logic        ok;
  int          n_mismatch = 0;
  int          checks = 0;
  always #2.5 pclk = ~pclk;
  hub_bus_frame_control #(.PROG_CYCLES(32'h64), .ERASE_CYCLES(32'hC8))
  hub_bus_frame_control_i (.pclk(pclk), .presetn(presetn), .ce(1'h1),
    .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .init_n(init_n), .iface_select_strap(iface_select_strap),
    .frame_ctl_n(frame_ctl_n), .nibble_bus_in(nibble_bus_in),
    .nibble_bus_out(nibble_bus_out), .nibble_bus_oe(nibble_bus_oe),
    .select_strap_pins(ID), .general_inputs(gpi),
    .top_boot_lock_n(top_boot_lock_n), .write_protect_n(write_protect_n),
    .ready_busy_out(ready_busy_out), .ready_busy_oe(ready_busy_oe),
    .standby(standby));
  hub_host hub_host_i (.pclk(pclk), .frame_ctl_n(frame_ctl_n),
    .nibble_bus_in(nibble_bus_in), .nibble_bus_out(nibble_bus_out),
    .nibble_bus_oe(nibble_bus_oe));
  task automatic end_sim();
    $display("mismatches %0d checks %0d", n_mismatch, checks);
    if (n_mismatch == 0 && checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] x,
    input logic [31:0] y);
    checks++;
    if (y !== x) begin
      $display("unexpected %s expected %h seen %h", n, x, y);
      n_mismatch++;
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a);
    int k;
    @(posedge pclk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= 32'hFFFFFFFF;
    @(posedge pclk);
    penable <= 1'h1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'h1 && k < 20);
    if (pready !== 1'h1) begin
      n_mismatch++;
      end_sim();
    end
    q = prdata;
    e = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  task automatic hub(input logic [3:0] s, input logic [27:0] a,
    input logic [7:0] d);
    hub_host_i.cycle(s, ID, a, d, b, ok);
  endtask
  task automatic prog(input logic [27:0] a);
    hub(4'hE, a, 8'h40);
    hub(4'hE, a, 8'h5A);
  endtask
  task automatic wait_done();
    int k;
    k = 0;
    do begin
      hub(4'hD, A_MN, 8'h00);
      k++;
    end while (b[7] !== 1'h1 && k < 20);
    chk("done", 8'h80, b);
  endtask
  task automatic pulse_init(input logic s);
    iface_select_strap <= s;
    init_n <= 1'h0;
    repeat (2) @(posedge pclk);
    init_n <= 1'h1;
    repeat (2) @(posedge pclk);
  endtask
  task automatic t_regs();
    apb(1'h0, 12'h004);
    chk("status", 32'h80, q & 32'hFF);
    apb(1'h0, 12'h008);
    chk("inputs", 32'h15, q);
    apb(1'h0, 12'h00C);
    chk("id", 32'hA, q);
    apb(1'h1, 12'h010);
    chk("slave error", 1'h1, e);
  endtask
  task automatic t_frames();
    gpi <= 5'h0A;
    hub(4'hD, A_GPI, 8'h00);
    chk("gpi", 9'h10A, {ok, b});
    repeat (2) @(posedge pclk);
    chk("standby", 1'h1, standby);
    hub_host_i.cycle(4'hD, 4'h5, A_GPI, 8'h00, b, ok);
    chk("other id", 1'h0, ok);
    hub(4'h5, A_GPI, 8'h00);
    chk("bad start", 1'h0, ok);
  endtask
  task automatic t_prog();
    prog(A_MN);
    chk("busy", 1'h1, ready_busy_oe);
    chk("busy level", 1'h0, ready_busy_out);
    hub(4'hD, A_MN, 8'h00);
    chk("done", 1'h0, b[7]);
    e = b[6];
    hub(4'hD, A_MN, 8'h00);
    chk("toggle", !e, b[6]);
    wait_done();
    chk("busy", 1'h0, ready_busy_oe);
  endtask
  task automatic t_prot();
    top_boot_lock_n <= 1'h0;
    prog(A_BT);
    hub(4'hD, A_BT, 8'h00);
    chk("boot lock", 9'h092, {ready_busy_oe, b});
    hub(4'hE, A_MN, 8'h50);
    top_boot_lock_n <= 1'h1;
    write_protect_n <= 1'h0;
    prog(A_MN);
    hub(4'hD, A_MN, 8'h00);
    chk("protect", 9'h092, {ready_busy_oe, b});
    apb(1'h1, 12'h000);
    apb(1'h0, 12'h004);
    chk("clear", 32'h80, q & 32'hFF);
    hub(4'hE, A_MN, 8'h50);
    prog(A_BT);
    chk("boot open", 1'h1, ready_busy_oe);
    wait_done();
    write_protect_n <= 1'h1;
  endtask
  task automatic t_abort();
    hub_host_i.nib(1'h0, 4'hE);
    hub_host_i.nib(1'h1, ID);
    repeat (4) hub_host_i.nib(1'h0, 4'hF);
    apb(1'h0, 12'h004);
    chk("abort wait", 1'h1, q[10]);
    hub_host_i.nib(1'h1, 4'hF);
    hub_host_i.rel();
    hub(4'hD, A_GPI, 8'h00);
    chk("after abort", 1'h1, ok);
    hub(4'hE, A_MN, 8'hFF);
    apb(1'h0, 12'h004);
    chk("abort status", 32'h80, q & 32'h4FF);
    hub(4'hD, A_MN, 8'h00);
    chk("array", 8'hFF, b);
  endtask
  task automatic t_erase();
    hub(4'hE, A_MN, 8'h20);
    hub(4'hE, A_MN, 8'h00);
    hub(4'hD, A_MN, 8'h00);
    chk("bad confirm", 9'h0B0, {ready_busy_oe, b});
    hub(4'hE, A_MN, 8'h50);
    write_protect_n <= 1'h0;
    hub(4'hE, A_MN, 8'h20);
    hub(4'hE, A_MN, 8'hD0);
    hub(4'hD, A_MN, 8'h00);
    chk("erase lock", 9'h0A2, {ready_busy_oe, b});
    write_protect_n <= 1'h1;
  endtask
  task automatic t_init();
    prog(A_MN);
    repeat (8) @(posedge pclk);
    pulse_init(1'h1);
    chk("busy", 1'h0, ready_busy_oe);
    apb(1'h0, 12'h004);
    chk("init status", 32'h280, q & 32'h2FF);
    hub(4'hD, A_GPI, 8'h00);
    chk("production", 1'h0, ok);
    pulse_init(1'h0);
    hub(4'hD, A_GPI, 8'h00);
    chk("hub mode", 1'h1, ok);
  endtask
  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1'h1;
    repeat (2) @(posedge pclk);
    t_regs();
    t_frames();
    t_prog();
    t_prot();
    t_abort();
    t_erase();
    t_init();
    end_sim();
  end
endmodule
